// ### cas_alarm_status.sv
// sticky alarm status register with output forcing and bus slave
//
// Design decision made here: the Avalon-MM register port.
`include "cas_consts.svh"

module cas_alarm_status (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset
  input wire cas_pkg::cas_avs_req_s avs_req, // avalon request
  output logic [31:0] avs_readdata, // avalon read data
  output logic avs_waitrequest, // avalon wait
  input wire logic conv_clk, // conversion clock pin
  input wire logic data_clk, // input data clock pin
  input wire logic [15:0] data_pins, // input data bus
  input wire logic parity_pin, // parity bit pin
  input wire logic frame_pin, // frame strobe pin
  input wire logic [7:0] fifo_wptr, // one-hot write pointer
  input wire logic [7:0] fifo_rptr, // one-hot read pointer
  input wire logic pll_locked, // pll lock pin
  input wire logic [63:0] proc_data, // processed samples
  output logic [63:0] dac_out, // samples to converter
  output logic alarm_out // unmasked alarm present
);
  import cas_pkg::*;

  ////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [2:0] onehot_idx(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [2:0] dist_code(input logic [2:0] d);
    logic [2:0] c;
    c = 3'h0;
    if (d == 3'h0) begin
      c = 3'h4;
    end else if (d == 3'h1 || d == 3'h7) begin
      c = 3'h2;
    end else if (d == 3'h2 || d == 3'h6) begin
      c = 3'h1;
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////
  // registers and state

  logic [15:0] status;
  logic [15:0] mask;
  logic [15:0] pattern;
  cas_ctrl_s ctrl;
  cas_bus_e state;
  logic [15:0] data_s1;
  logic [15:0] data_s2;
  logic [1:0] par_s;
  logic [1:0] frame_s;
  logic [1:0] pll_s;
  logic iotest_err;

  ////////////////////////////////////////////////////////////
  // pin sampling

  // data and clock pass equal sync depth, so the data stays
  // aligned with the detected edge; needs data stable about
  // one clk_sys cycle (10 ns) around each data clock edge
  always_ff @(posedge clk_sys) begin
    data_s1 <= data_pins;
    data_s2 <= data_s1;
    par_s <= {par_s[0], parity_pin};
    frame_s <= {frame_s[0], frame_pin};
    pll_s <= {pll_s[0], pll_locked};
  end

  logic dclk_rise;
  logic dclk_fall;
  logic dclk_gone;
  logic cclk_gone;

  cas_clk_mon u_data_mon (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_pin(data_clk),
    .rise(dclk_rise),
    .fall(dclk_fall),
    .gone(dclk_gone)
  );

  cas_clk_mon u_conv_mon (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_pin(conv_clk),
    .rise(),
    .fall(),
    .gone(cclk_gone)
  );

  ////////////////////////////////////////////////////////////
  // parity and pattern checks

  logic rpar_err;
  logic fpar_err;
  logic frpar_err;
  wire frame_strobe = dclk_rise & ctrl.frame_par;

  cas_parity u_rpar (
    .clk_sys(clk_sys),
    .reset(reset),
    .strobe(dclk_rise),
    .data(data_s2),
    .par(par_s[1]),
    .err(rpar_err)
  );

  cas_parity u_fpar (
    .clk_sys(clk_sys),
    .reset(reset),
    .strobe(dclk_fall),
    .data(data_s2),
    .par(par_s[1]),
    .err(fpar_err)
  );

  cas_parity u_frpar (
    .clk_sys(clk_sys),
    .reset(reset),
    .strobe(frame_strobe),
    .data(data_s2),
    .par(frame_s[1]),
    .err(frpar_err)
  );

  wire data_strobe = dclk_rise | dclk_fall;
  wire pat_miss = data_strobe & (data_s2 != pattern);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      iotest_err <= 1'b0;
    end else begin
      iotest_err <= ctrl.pat_mode & pat_miss;
    end
  end

  ////////////////////////////////////////////////////////////
  // alarm events

  wire [2:0] w_idx = onehot_idx(fifo_wptr);
  wire [2:0] r_idx = onehot_idx(fifo_rptr);
  wire ptr_zero = (fifo_wptr == 8'h00);
  wire [2:0] fifo_code = dist_code(3'(w_idx - r_idx));
  wire [2:0] fifo_ev = ptr_zero ? 3'h0 : fifo_code;
  wire pll_lost = ~pll_s[1];
  logic out_cause;

  logic [15:0] ev_raw;
  always_comb begin
    ev_raw = 16'h0000;
    ev_raw[`CAS_B_ZERO] = ptr_zero;
    ev_raw[`CAS_B_COLL] = fifo_ev[2];
    ev_raw[`CAS_B_ONE] = fifo_ev[1];
    ev_raw[`CAS_B_TWO] = fifo_ev[0];
    ev_raw[`CAS_B_DACCLK] = cclk_gone;
    ev_raw[`CAS_B_DATACLK] = dclk_gone;
    ev_raw[`CAS_B_OUT] = out_cause;
    ev_raw[`CAS_B_PLL] = pll_lost;
    ev_raw[`CAS_B_RPAR] = rpar_err;
    ev_raw[`CAS_B_FPAR] = fpar_err;
    ev_raw[`CAS_B_FRPAR] = frpar_err;
  end

  // pattern mode: the live checks see test data, so they are held off
  wire [15:0] ev_mode = ctrl.pat_mode ? 16'h0000 : ev_raw;
  wire [15:0] ev_iot = {8'h00, iotest_err, 7'h00};
  wire [15:0] events = (ev_mode | ev_iot) & `CAS_USED_BITS;

  ////////////////////////////////////////////////////////////
  // bus slave

  wire [5:0] idx = avs_req.address[7:2];
  wire req = avs_req.read | avs_req.write;
  wire hit_status = (idx == `CAS_IDX_STATUS);
  wire hit_mask = (idx == `CAS_IDX_MASK);
  wire hit_ctrl = (idx == `CAS_IDX_CTRL);
  wire hit_pat = (idx == `CAS_IDX_PATTERN);
  wire wr_now = (state == CAS_ACK) & avs_req.write;
  wire [15:0] wdata = avs_req.writedata[15:0];
  wire [15:0] clr = (wr_now & hit_status)
    ? (wdata & `CAS_USED_BITS) : 16'h0000;

  wire [15:0] rd_mux = hit_status ? status
    : hit_mask ? mask
    : hit_ctrl ? {11'h000, ctrl}
    : hit_pat ? pattern
    : 16'h0000;

  // one wait cycle; write lands at the edge that ends the following ack cycle, one edge after the wait ends
  assign avs_waitrequest = req & (state == CAS_IDLE);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= CAS_IDLE;
    end else begin
      unique case (state)
        CAS_IDLE: begin
          if (req) begin
            state <= CAS_ACK;
          end
        end
        CAS_ACK: begin
          state <= CAS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (state == CAS_IDLE && avs_req.read) begin
      avs_readdata <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mask <= `CAS_MASK_RST;
      ctrl <= cas_ctrl_s'(`CAS_CTRL_RST);
      pattern <= `CAS_PATTERN_RST;
    end else if (wr_now) begin
      if (hit_mask) begin
        mask <= wdata;
      end
      if (hit_ctrl) begin
        ctrl <= cas_ctrl_s'(wdata[4:0]);
      end
      if (hit_pat) begin
        pattern <= wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // sticky status, set wins over clear

  // reset only empties the bits; live faults refill them at once
  // a cause bit cleared in this very write must not keep the forced bit alive
  wire [15:0] kept = status & ~clr;
  assign out_cause = kept[`CAS_B_DACCLK] | kept[`CAS_B_DATACLK]
    | kept[`CAS_B_COLL] | cclk_gone | dclk_gone | fifo_ev[2];
  wire [15:0] next_status = kept | events;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status <= `CAS_STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs

  wire force_mid = status[`CAS_B_OUT] & (
    (status[`CAS_B_DACCLK] & ctrl.halt_dacclk)
    | (status[`CAS_B_DATACLK] & ctrl.halt_dataclk)
    | (status[`CAS_B_COLL] & ctrl.halt_coll));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dac_out <= {4{`CAS_MIDSCALE}};
    end else if (force_mid) begin
      dac_out <= {4{`CAS_MIDSCALE}};
    end else begin
      dac_out <= proc_data;
    end
  end

  assign alarm_out = |(status & ~mask);

  ////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  wire [15:0] st_other = status & 16'hFF7F;
  wire no_clr = (clr == 16'h0000);

  property p_zero;
    ptr_zero && !ctrl.pat_mode |=> status[15];
  endproperty
  a_zero: assert property (p_zero) else $error("zero pointer missed");

  property p_coll;
    (fifo_wptr == fifo_rptr) && !ptr_zero && !ctrl.pat_mode
      |=> status[13] && status[8];
  endproperty
  a_coll: assert property (p_coll) else $error("collision missed");

  property p_two;
    !ptr_zero && fifo_code == 3'h1 && !ctrl.pat_mode |=> status[11];
  endproperty
  a_two: assert property (p_two) else $error("two apart missed");

  property p_cclk;
    cclk_gone && !ctrl.pat_mode |=> status[10];
  endproperty
  a_cclk: assert property (p_cclk) else $error("clock loss missed");

  property p_dclk;
    dclk_gone && !ctrl.pat_mode |=> status[9];
  endproperty
  a_dclk: assert property (p_dclk) else $error("data clock loss missed");

  property p_out;
    status[10] && !clr[10] && !ctrl.pat_mode |=> status[8];
  endproperty
  a_out: assert property (p_out) else $error("forced bit missed");

  property p_mid;
    status[8] && status[13] && ctrl.halt_coll
      |=> dac_out[15:0] == 16'h8000 && dac_out[63:48] == 16'h8000;
  endproperty
  a_mid: assert property (p_mid) else $error("mid-scale not driven");

  property p_iot;
    ctrl.pat_mode && pat_miss |=> ##1 status[7];
  endproperty
  a_iot: assert property (p_iot) else $error("pattern miss lost");

  property p_quiet;
    ctrl.pat_mode && $past(ctrl.pat_mode) && no_clr |=> $stable(st_other);
  endproperty
  a_quiet: assert property (p_quiet) else $error("alarm moved in test mode");

  property p_pll;
    pll_lost && !ctrl.pat_mode |=> status[5];
  endproperty
  a_pll: assert property (p_pll) else $error("pll loss missed");

  property p_rpar;
    rpar_err && !ctrl.pat_mode |=> status[4];
  endproperty
  a_rpar: assert property (p_rpar) else $error("rise parity lost");

  property p_clear;
    clr[2] && !events[2] |=> !status[2];
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");

  property p_sticky;
    status[15] && !clr[15] |=> status[15];
  endproperty
  a_sticky: assert property (p_sticky) else $error("alarm dropped");

  property p_resv;
    (status & 16'h4043) == 16'h0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");

  property p_mask;
    mask == 16'hFFFF |-> !alarm_out;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alarm shown");

  c_clear: cover property (wr_now && hit_status && clr != 16'h0000);
  c_force: cover property (force_mid ##1 !force_mid);
  c_iot: cover property (ctrl.pat_mode ##1 status[7]);
endmodule

// ### cas_consts.svh
// constants of the converter alarm status block
`ifndef CAS_CONSTS_SVH
`define CAS_CONSTS_SVH

// register indexes, byte address is index times four
`define CAS_IDX_STATUS 6'h05
`define CAS_IDX_MASK 6'h07
`define CAS_IDX_CTRL 6'h10
`define CAS_IDX_PATTERN 6'h11

// reset values
`define CAS_MASK_RST 16'hFFFF
`define CAS_CTRL_RST 5'h00
`define CAS_PATTERN_RST 16'h0000
`define CAS_STATUS_RST 16'h0000

// bits that the alarm logic may own
`define CAS_USED_BITS 16'hBFBC
`define CAS_MIDSCALE 16'h8000

// status bit positions
`define CAS_B_ZERO 15
`define CAS_B_COLL 13
`define CAS_B_ONE 12
`define CAS_B_TWO 11
`define CAS_B_DACCLK 10
`define CAS_B_DATACLK 9
`define CAS_B_OUT 8
`define CAS_B_IOTEST 7
`define CAS_B_PLL 5
`define CAS_B_RPAR 4
`define CAS_B_FPAR 3
`define CAS_B_FRPAR 2

// clock-loss timeout
`define CAS_CLK_MHZ 100
`define CAS_GONE_NS 1000
`define CAS_GONE_CYC ((`CAS_GONE_NS * `CAS_CLK_MHZ) / 1000)
`define CAS_GONE_W 12

`endif

// ### cas_pkg.sv
// types of the converter alarm status block
package cas_pkg;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } cas_avs_req_s;

  typedef struct packed {
    logic halt_dacclk;
    logic halt_dataclk;
    logic halt_coll;
    logic frame_par;
    logic pat_mode;
  } cas_ctrl_s;

  typedef enum logic [1:0] {
    CAS_IDLE = 2'b01,
    CAS_ACK = 2'b10
  } cas_bus_e;

endpackage

// ### cas_clk_mon.sv
// clock pin sampler: edge pulses and loss detection
`include "cas_consts.svh"

module cas_clk_mon (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset
  input wire logic clk_pin, // watched clock pin
  output logic rise, // one-cycle rising edge pulse
  output logic fall, // one-cycle falling edge pulse
  output logic gone // no edge within the timeout
);
  logic sync1;
  logic sync2;
  logic last;
  logic [`CAS_GONE_W-1:0] idle_cnt;
  wire [`CAS_GONE_W-1:0] gone_lim = `CAS_GONE_W'(`CAS_GONE_CYC);
  wire edge_seen = sync2 ^ last;

  always_ff @(posedge clk_sys) begin
    sync1 <= clk_pin;
    sync2 <= sync1;
    last <= sync2;
  end

  // saturating counter, so a stopped clock keeps the loss level
  always_ff @(posedge clk_sys) begin
    if (reset || edge_seen) begin
      idle_cnt <= '0;
    end else if (idle_cnt != gone_lim) begin
      idle_cnt <= idle_cnt + `CAS_GONE_W'(1);
    end
  end

  assign rise = sync2 & ~last;
  assign fall = ~sync2 & last;
  assign gone = (idle_cnt == gone_lim);
endmodule

// ### cas_parity.sv
// even parity checker on one captured word
module cas_parity (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset
  input wire logic strobe, // word valid this cycle
  input wire logic [15:0] data, // captured word
  input wire logic par, // parity bit with the word
  output logic err // one-cycle parity error pulse
);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      err <= 1'b0;
    end else begin
      err <= strobe & (^{data, par});
    end
  end

  property p_err;
    @(posedge clk_sys) disable iff (reset)
      strobe && (^{data, par}) |=> err;
  endproperty
  a_err: assert property (p_err) else $error("parity error not flagged");
endmodule

// ### cas_src_model.sv
// data source model driving the input data bus and its clock
module cas_src_model (
  input wire logic run, // frame active, link clock runs
  input wire logic bad_par, // send wrong parity
  input wire logic [15:0] word, // word to send
  output logic data_clk, // link clock, 125 ns
  output logic [15:0] data_pins, // data bus
  output logic parity_pin, // parity bit
  output logic frame_pin // frame line as parity
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    data_clk = 1'b0;
    data_pins = 16'h0000;
    parity_pin = 1'b0;
    frame_pin = 1'b0;
    forever begin
      #31.2;
      // data moves midway between edges; outside frames it keeps changing
      data_pins = run ? word : ~data_pins;
      parity_pin = ^data_pins ^ bad_par;
      frame_pin = parity_pin;
      #31.3;
      if (run) begin
        data_clk = ~data_clk;
      end
    end
  end
endmodule

// ### test_cas_alarm_status.sv
// self-checking bench of the alarm status block
`include "cas_consts.svh"

module test_cas_alarm_status;
  import cas_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] a_st = {`CAS_IDX_STATUS, 2'b00};
  localparam logic [7:0] a_mk = {`CAS_IDX_MASK, 2'b00};
  localparam logic [7:0] a_ct = {`CAS_IDX_CTRL, 2'b00};
  localparam logic [7:0] a_pt = {`CAS_IDX_PATTERN, 2'b00};
  logic clk_sys = 1'b0;
  logic reset;
  cas_avs_req_s avs_req;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic conv_clk, conv_run, run, bad_par, data_clk, parity_pin, frame_pin;
  logic pll_locked, alarm_out, z;
  logic [15:0] data_pins, word, e;
  logic [7:0] fifo_wptr, fifo_rptr;
  logic [63:0] proc_data, dac_out;
  logic [31:0] seed;
  logic [2:0] w, r;
  int error_cnt = 0;
  int compares = 0;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (conv_run) conv_clk <= ~conv_clk;

  cas_alarm_status i_dut (
    .clk_sys(clk_sys), .reset(reset), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_clk(conv_clk), .data_clk(data_clk),
    .data_pins(data_pins), .parity_pin(parity_pin), .frame_pin(frame_pin),
    .fifo_wptr(fifo_wptr), .fifo_rptr(fifo_rptr), .pll_locked(pll_locked),
    .proc_data(proc_data), .dac_out(dac_out), .alarm_out(alarm_out));

  cas_src_model i_src (
    .run(run), .bad_par(bad_par), .word(word), .data_clk(data_clk),
    .data_pins(data_pins), .parity_pin(parity_pin), .frame_pin(frame_pin));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] exp_fifo(input logic [2:0] wi, input logic [2:0] ri,
                                           input logic zero);
    logic [2:0] d;
    d = wi - ri;
    if (zero) return 16'h8000;
    case (d)
      3'h0: return 16'h2100;
      3'h1, 3'h7: return 16'h1000;
      3'h2, 3'h6: return 16'h0800;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic summarize;
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_req <= {~is_wr, is_wr, a, 16'h0000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_req <= '0;
    if (n >= 50) begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [15:0] x);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    cmp(what, {48'h0, x}, {32'h0, q});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    avs_req = '0;
    conv_clk = 1'b0;
    conv_run = 1'b1;
    run = 1'b1;
    bad_par = 1'b0;
    word = 16'h0000;
    fifo_wptr = 8'h01;
    fifo_rptr = 8'h10;
    pll_locked = 1'b1;
    proc_data = 64'h0;
    seed = 32'hFAF4;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rd("status", a_st, 16'h0000);
    rd("mask", a_mk, `CAS_MASK_RST);
    rd("unmapped", 8'h08, 16'h0000);
    // every pointer distance, then the zero pointer and random ones
    wr(a_ct, 16'h0004);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      w = seed[2:0];
      r = (i < 8) ? w - i[2:0] : seed[5:3];
      z = (i == 8);
      e = exp_fifo(w, r, z);
      fifo_wptr <= z ? 8'h00 : 8'h01 << w;
      fifo_rptr <= 8'h01 << r;
      proc_data <= {seed, ~seed};
      repeat (3) @(posedge clk_sys);
      wr(a_st, 16'hFFFF);
      rd("fifo status", a_st, e);
      cmp("dac out", e[13] ? {4{`CAS_MIDSCALE}} : {seed, ~seed}, dac_out);
    end
    fifo_wptr <= 8'h01;
    fifo_rptr <= 8'h10;
    repeat (3) @(posedge clk_sys);
    wr(a_st, 16'hFFFF);
    pll_locked <= 1'b0;
    repeat (3) @(posedge clk_sys);
    pll_locked <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wr(a_st, 16'h0000);
    rd("pll", a_st, 16'h0020);
    cmp("alarm masked", 64'h0, {63'h0, alarm_out});
    wr(a_mk, 16'hFFDF);
    rd("mask", a_mk, 16'hFFDF);
    cmp("alarm shown", 64'h1, {63'h0, alarm_out});
    wr(a_st, 16'h0020);
    rd("pll clear", a_st, 16'h0000);
    cmp("alarm gone", 64'h0, {63'h0, alarm_out});
    // conversion clock, then link clock, stops under halt enables
    wr(a_ct, 16'h0018);
    for (int k = 0; k < 2; k++) begin
      conv_run <= k[0];
      run <= !k[0];
      repeat (150) @(posedge clk_sys);
      rd("clock loss", a_st, k ? 16'h0300 : 16'h0500);
      cmp("dac forced", {4{`CAS_MIDSCALE}}, dac_out);
      conv_run <= 1'b1;
      run <= 1'b1;
      repeat (20) @(posedge clk_sys);
      wr(a_st, 16'hFFFF);
      rd("restart", a_st, 16'h0000);
      cmp("dac released", {seed, ~seed}, dac_out);
    end
    seed = lfsr(seed);
    word <= seed[15:0];
    wr(a_ct, 16'h0002);
    bad_par <= 1'b1;
    repeat (40) @(posedge clk_sys);
    bad_par <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rd("parity", a_st, 16'h001C);
    wr(a_st, 16'h001C);
    rd("parity clear", a_st, 16'h0000);
    // pattern mode hides every event but the mismatch
    seed = lfsr(seed);
    word <= seed[15:0];
    wr(a_pt, seed[15:0]);
    wr(a_ct, 16'h0001);
    repeat (30) @(posedge clk_sys);
    wr(a_st, 16'hFFFF);
    rd("pattern match", a_st, 16'h0000);
    word <= ~seed[15:0];
    pll_locked <= 1'b0;
    bad_par <= 1'b1;
    repeat (30) @(posedge clk_sys);
    rd("pattern miss", a_st, 16'h0080);
    summarize();
  end
endmodule
